/* File: sto_defines.svh */
// Constants of the torque-cut supervisor: offsets, bit positions, reset values and timings.
// Assumes a 25 MHz system clock; included by bare name wherever a number is needed.
`ifndef STO_DEFINES_SVH
`define STO_DEFINES_SVH

// System clock rate in hertz.
`define STO_CLK_HZ 64'd25000000
// Longest test pulse that is ignored, in microseconds.
`define STO_PULSE_US 64'd1000
// Longest stay in the undefined band before an error, in microseconds.
`define STO_BAND_US 64'd500000
// Least time in microseconds to cycles, rounded up.
`define STO_US_TO_CYC(us) (((us) * `STO_CLK_HZ + 64'd999999) / 64'd1000000)
`define STO_PULSE_CYC 32'(`STO_US_TO_CYC(`STO_PULSE_US))
`define STO_BAND_CYC 32'(`STO_US_TO_CYC(`STO_BAND_US))

// Register byte offsets.
`define STO_OFS_CTRL 8'h00
`define STO_OFS_STAT 8'h04
`define STO_OFS_ALARM 8'h08
`define STO_OFS_IRQ_STAT 8'h0C
`define STO_OFS_IRQ_MASK 8'h10

// Control register bits, each a write-one command.
`define STO_CTRL_ENABLE 0
`define STO_CTRL_DISABLE 1
`define STO_CTRL_CLEAR 2

// Status register bits.
`define STO_STAT_STOP_HIGH 0
`define STO_STAT_RUN 1
`define STO_STAT_TORQUE 2
`define STO_STAT_BAND 3

// Reset values.
`define STO_RST_ALARM 3'h0
`define STO_RST_IRQ 4'h0
`define STO_RST_MASK 4'h0

`endif

/* File: sto_pkg.sv */
// Types shared by the torque-cut supervisor modules.
// Assumes nothing beyond a SystemVerilog compiler.
package sto_pkg;

    // Latched safety alarms, also the low three interrupt bits.
    typedef struct packed {
        logic band_err;  // Input stayed in the undefined band.
        logic act_stop;  // Enable asked for while stop input low.
        logic stop_en;   // Stop input fell while drive enabled.
    } sto_alarm_t;

    // Interrupt events: a new alarm of each kind, or torque being cut.
    typedef struct packed {
        logic       cut;
        sto_alarm_t alarm;
    } sto_evt_t;

    // Drive enable state.
    typedef enum logic {
        DRV_IDLE,
        DRV_RUN
    } sto_drv_t;

endpackage

/* File: sto_filt.sv */
// Pin conditioner: three-flop synchroniser and a persistence filter.
// Assumes raw_in is asynchronous to clock_in; one instance per pin.
`timescale 1ns/1ps
`default_nettype none

module sto_filt #(
    parameter logic        ACTIVE = 1'b0,  // Level that must persist to count.
    parameter logic        RST    = 1'b0,  // Level assumed while in reset.
    parameter int unsigned DLY    = 32'd1  // Cycles the level must outlast.
) (
    input  wire logic clock_in,
    input  wire logic rst_in,
    input  wire logic raw_in,
    output var  logic level_out
);

    logic        s1_reg;   // First flop, read only by the second.
    logic        s2_reg;   // Second flop.
    logic        s3_reg;   // Third flop.
    logic [31:0] cnt_reg;  // Cycles the active level has persisted.
    logic        lvl_reg;  // Filtered level.

    // Synchroniser chain; a change counts once the second and third agree.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            s1_reg <= RST;
            s2_reg <= RST;
            s3_reg <= RST;
        end else begin
            s1_reg <= raw_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // The active level wins only after it outlasts DLY cycles, so shorter
    // excursions vanish; the inactive level takes over at once.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_reg <= 32'h0;
            lvl_reg <= RST;
        end else if (s2_reg == s3_reg && s3_reg == ACTIVE) begin
            if (cnt_reg == DLY) begin
                lvl_reg <= ACTIVE;
            end else begin
                cnt_reg <= cnt_reg + 32'h1;
            end
        end else begin
            cnt_reg <= 32'h0;
            if (s2_reg == s3_reg) begin
                lvl_reg <= s3_reg;
            end
        end
    end

    assign level_out = lvl_reg;

    // Turning active needs more than DLY cycles of agreement.
    property p_persist;
        @(posedge clock_in) disable iff (rst_in)
        $changed(lvl_reg) && lvl_reg == ACTIVE |-> $past(cnt_reg) == DLY;
    endproperty
    a_persist: assert property (p_persist) else $error("Active too early.");

endmodule

`default_nettype wire

/* File: sto_supervisor.sv */
// Top of the torque-cut supervisor: pin filtering, alarm latches, drive
// enable, torque output and a classic Wishbone register slave.
// Assumes a 25 MHz clock_in, asynchronous active-high rst_in, and a band
// comparator that reports when the stop input sits between thresholds.
`timescale 1ns/1ps
`default_nettype none
`include "sto_defines.svh"

module sto_supervisor
    import sto_pkg::*;
#(
    parameter int unsigned PULSE_CYC = `STO_PULSE_CYC,  // Test pulse allowance.
    parameter int unsigned BAND_CYC  = `STO_BAND_CYC    // Undefined band limit.
) (
    input  wire logic        clock_in,
    input  wire logic        rst_in,
    input  wire logic        torque_cut_input_n,  // Stop pin, low means stop.
    input  wire logic        band_undef_in,       // High while level is undefined.
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [7:0]  wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output var  logic [31:0] wb_dat_out,
    output var  logic        wb_ack_out,
    output var  logic        torque_en_out,       // Gate driver power enable.
    output var  logic        irq_out
);

    // True when an address selects the given register offset.
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
        hit = (adr[7:2] == ofs[7:2]);
    endfunction

    logic        stop_ok;        // Filtered stop input, high permits torque.
    logic        band_bad;       // Undefined band outlasted its limit.
    logic        ack_reg;        // Bus acknowledge.
    logic [31:0] rdat_reg;       // Bus read data.
    logic        fire;           // Edge at which the master takes the ack.
    logic        wr_fire;        // Write takes effect now.
    logic        rd_fire;        // Read completes now.
    logic        en_cmd;         // Enable command.
    logic        dis_cmd;        // Disable command.
    logic        clr_cmd;        // Alarm clear command.
    logic        clr_ok;         // Clear accepted, input is high.
    sto_alarm_t  alarm_reg;      // Latched alarms.
    sto_alarm_t  alarm_set;      // Alarm causes this cycle.
    sto_alarm_t  alarm_next;     // Next latched alarms.
    sto_drv_t    drv_reg;        // Drive enable state.
    sto_drv_t    drv_next;       // Next drive state.
    logic        torque_reg;     // Torque permitted.
    logic        torque_next;    // Next torque permission.
    sto_evt_t    evt;            // Interrupt events this cycle.
    logic [3:0]  irq_stat_reg;   // Sticky interrupt status.
    logic [3:0]  irq_stat_next;  // Next sticky status.
    logic [3:0]  irq_mask_reg;   // Interrupt mask, one enables.
    logic        irq_reg;        // Interrupt output flop.

    // Stop pin: lows no longer than the test pulse allowance are dropped.
    sto_filt #(
        .ACTIVE (1'b0),
        .RST    (1'b0),
        .DLY    (PULSE_CYC)
    ) u_stop (
        .clock_in  (clock_in),
        .rst_in    (rst_in),
        .raw_in    (torque_cut_input_n),
        .level_out (stop_ok)
    );

    // Band comparator: reports only once the stay outlasts its limit.
    sto_filt #(
        .ACTIVE (1'b1),
        .RST    (1'b0),
        .DLY    (BAND_CYC)
    ) u_band (
        .clock_in  (clock_in),
        .rst_in    (rst_in),
        .raw_in    (band_undef_in),
        .level_out (band_bad)
    );

    // Bus strobes. Writes and read side effects act at the ack edge, the
    // only edge at which the master commits to the transfer.
    assign fire    = wb_cyc_in & wb_stb_in & ack_reg;
    assign wr_fire = fire & wb_we_in & wb_sel_in[0];
    assign rd_fire = fire & ~wb_we_in;
    assign en_cmd  = wr_fire & hit(wb_adr_in, `STO_OFS_CTRL) & wb_dat_in[`STO_CTRL_ENABLE];
    assign dis_cmd = wr_fire & hit(wb_adr_in, `STO_OFS_CTRL) & wb_dat_in[`STO_CTRL_DISABLE];
    assign clr_cmd = wr_fire & hit(wb_adr_in, `STO_OFS_CTRL) & wb_dat_in[`STO_CTRL_CLEAR];

    // A clear is honoured only once the input is back high.
    assign clr_ok = clr_cmd & stop_ok;

    // Alarm causes. A disabled drive may see the input fall without alarm.
    always_comb begin
        alarm_set          = sto_alarm_t'(3'h0);
        alarm_set.stop_en  = (drv_reg == DRV_RUN) & ~stop_ok;
        alarm_set.act_stop = en_cmd & ~stop_ok;
        alarm_set.band_err = band_bad;
    end

    // A cause in the same cycle as a clear wins, so no event is lost; the
    // input going high does not clear anything by itself.
    assign alarm_next = sto_alarm_t'((alarm_reg & ~{3{clr_ok}}) | alarm_set);

    // Alarm latches.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            alarm_reg <= sto_alarm_t'(`STO_RST_ALARM);
        end else begin
            alarm_reg <= alarm_next;
        end
    end

    // Drive state: starts only on an explicit enable with the input high
    // and no alarm; drops on disable, input low or any alarm.
    always_comb begin
        drv_next = drv_reg;
        unique case (drv_reg)
            DRV_IDLE: begin
                if (en_cmd && stop_ok && alarm_reg == 3'h0) begin
                    drv_next = DRV_RUN;
                end
            end
            DRV_RUN: begin
                if (dis_cmd || !stop_ok || alarm_reg != 3'h0) begin
                    drv_next = DRV_IDLE;
                end
            end
        endcase
    end

    // Drive state register.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            drv_reg <= DRV_IDLE;
        end else begin
            drv_reg <= drv_next;
        end
    end

    // Torque needs all three conditions every cycle. There is no override
    // term here on purpose: no mode or command can hold torque on.
    assign torque_next = (drv_reg == DRV_RUN) & stop_ok & (alarm_reg == 3'h0);

    // Torque output flop. Registering it costs one cycle of cut latency but
    // keeps the gate driver enable free of decode glitches, which matters
    // more here than the extra 40 ns.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            torque_reg <= 1'b0;
        end else begin
            torque_reg <= torque_next;
        end
    end

    // Events: newly raised alarms and the loss of torque.
    always_comb begin
        evt       = sto_evt_t'(4'h0);
        evt.alarm = sto_alarm_t'(alarm_set & ~alarm_reg);
        evt.cut   = torque_reg & ~torque_next;
    end

    // Sticky status cleared by reading it; a new event wins over the read.
    always_comb begin
        irq_stat_next = irq_stat_reg;
        if (rd_fire && hit(wb_adr_in, `STO_OFS_IRQ_STAT)) begin
            irq_stat_next = 4'h0;
        end
        irq_stat_next = irq_stat_next | evt;
    end

    // Interrupt status, mask and output level.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            irq_stat_reg <= `STO_RST_IRQ;
            irq_mask_reg <= `STO_RST_MASK;
            irq_reg      <= 1'b0;
        end else begin
            irq_stat_reg <= irq_stat_next;
            if (wr_fire && hit(wb_adr_in, `STO_OFS_IRQ_MASK)) begin
                irq_mask_reg <= wb_dat_in[3:0];
            end
            irq_reg <= |(irq_stat_next & irq_mask_reg);
        end
    end

    // Bus slave: ack one cycle after the request, dropped the cycle after.
    // Read data is captured with the ack, before any read-clear acts.
    // Unmapped addresses still answer, with zero data, so a stray access
    // can never leave the master waiting.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            ack_reg  <= 1'b0;
            rdat_reg <= 32'h0;
        end else begin
            ack_reg  <= wb_cyc_in & wb_stb_in & ~ack_reg;
            rdat_reg <= 32'h0;
            if (wb_cyc_in && wb_stb_in && !ack_reg && !wb_we_in) begin
                if (hit(wb_adr_in, `STO_OFS_STAT)) begin
                    rdat_reg[`STO_STAT_STOP_HIGH] <= stop_ok;
                    rdat_reg[`STO_STAT_RUN]       <= (drv_reg == DRV_RUN);
                    rdat_reg[`STO_STAT_TORQUE]    <= torque_reg;
                    rdat_reg[`STO_STAT_BAND]      <= band_bad;
                end else if (hit(wb_adr_in, `STO_OFS_ALARM)) begin
                    rdat_reg[2:0] <= alarm_reg;
                end else if (hit(wb_adr_in, `STO_OFS_IRQ_STAT)) begin
                    rdat_reg[3:0] <= irq_stat_reg;
                end else if (hit(wb_adr_in, `STO_OFS_IRQ_MASK)) begin
                    rdat_reg[3:0] <= irq_mask_reg;
                end
            end
        end
    end

    assign wb_ack_out    = ack_reg;
    assign wb_dat_out    = rdat_reg;
    assign torque_en_out = torque_reg;
    assign irq_out       = irq_reg;

    // Checks on the supervisor's own behaviour.
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    // Input low means no torque on the following edge.
    property p_stop_cut;
        !stop_ok |=> !torque_en_out;
    endproperty
    a_stop_cut: assert property (p_stop_cut) else $error("Torque with stop low.");

    // A clear with the input low leaves the alarms untouched.
    property p_clear_order;
        clr_cmd && !stop_ok && alarm_set == 3'h0 |=> alarm_reg == $past(alarm_reg);
    endproperty
    a_clear_order: assert property (p_clear_order) else $error("Clear taken low.");

    // Torque only follows a cycle of input high, run and no alarm.
    property p_no_bypass;
        torque_en_out |-> $past(stop_ok) && $past(alarm_reg) == 3'h0 && $past(drv_reg) == DRV_RUN;
    endproperty
    a_no_bypass: assert property (p_no_bypass) else $error("Torque without cause.");

    // Running with input high and no alarm gives torque.
    property p_run_torque;
        drv_reg == DRV_RUN && stop_ok && alarm_reg == 3'h0 |=> torque_en_out;
    endproperty
    a_run_torque: assert property (p_run_torque) else $error("No torque when due.");

    // An idle drive seeing the input fall raises no stop alarm.
    property p_quiet_stop;
        drv_reg == DRV_IDLE && $fell(stop_ok) && !alarm_reg.stop_en |=> !alarm_reg.stop_en;
    endproperty
    a_quiet_stop: assert property (p_quiet_stop) else $error("Alarm on idle stop.");

    // Enable while low: alarm next, no torque for two cycles.
    sequence s_held_off;
        alarm_reg.act_stop && !torque_en_out ##1 !torque_en_out;
    endsequence
    property p_act_stop;
        en_cmd && !stop_ok |=> s_held_off;
    endproperty
    a_act_stop: assert property (p_act_stop) else $error("Enable while low missed.");

    // Input returning high keeps the alarm and holds torque off.
    property p_alarm_holds;
        alarm_reg.act_stop && $rose(stop_ok) && !clr_cmd |=> alarm_reg.act_stop && !torque_en_out;
    endproperty
    a_alarm_holds: assert property (p_alarm_holds) else $error("Alarm lost on rise.");

    // A clear with the input high and no new cause empties every alarm.
    property p_clear_ok;
        clr_ok && alarm_set == 3'h0 |=> alarm_reg == 3'h0;
    endproperty
    a_clear_ok: assert property (p_clear_ok) else $error("Clear left alarms.");

    // Clean enable: running next cycle and torque the cycle after, as long
    // as the input and the alarms still allow torque once the drive runs.
    sequence s_start;
        drv_reg == DRV_RUN ##1 torque_en_out;
    endsequence
    property p_start;
        en_cmd && stop_ok && alarm_reg == 3'h0 && drv_reg == DRV_IDLE && !band_bad
            |=> ((stop_ok && alarm_reg == 3'h0) |-> s_start);
    endproperty
    a_start: assert property (p_start) else $error("Enable did not start drive.");

    // Input falling while running: alarm latched and drive stopped.
    property p_stop_run;
        drv_reg == DRV_RUN && !stop_ok |=> alarm_reg.stop_en && drv_reg == DRV_IDLE;
    endproperty
    a_stop_run: assert property (p_stop_run) else $error("Stop while run missed.");

    // A pending alarm keeps an idle drive idle whatever the enable.
    property p_blocked;
        drv_reg == DRV_IDLE && alarm_reg != 3'h0 && en_cmd |=> drv_reg == DRV_IDLE;
    endproperty
    a_blocked: assert property (p_blocked) else $error("Enable passed an alarm.");

    // Any pending alarm holds torque off on the following edge.
    property p_alarm_cut;
        alarm_reg != 3'h0 |=> !torque_en_out;
    endproperty
    a_alarm_cut: assert property (p_alarm_cut) else $error("Torque with alarm.");

    // A band stay past its limit latches the band alarm on the next edge.
    property p_band_err;
        band_bad |=> alarm_reg.band_err;
    endproperty
    a_band_err: assert property (p_band_err) else $error("Band error missed.");

    // An idle drive never starts without an explicit enable command.
    property p_auto_start;
        drv_reg == DRV_IDLE && !en_cmd |=> drv_reg == DRV_IDLE;
    endproperty
    a_auto_start: assert property (p_auto_start) else $error("Self-start.");

    // Disable: idle next cycle and torque gone the cycle after.
    sequence s_stopped;
        drv_reg == DRV_IDLE ##1 !torque_en_out;
    endsequence
    property p_disable;
        dis_cmd && !en_cmd |=> s_stopped;
    endproperty
    a_disable: assert property (p_disable) else $error("Disable ignored.");

    // Losing the input under torque posts both the alarm and the cut event.
    property p_stop_irq;
        drv_reg == DRV_RUN && torque_en_out && !stop_ok |=> irq_stat_reg[0] && irq_stat_reg[3];
    endproperty
    a_stop_irq: assert property (p_stop_irq) else $error("Stop events missing.");

endmodule

`default_nettype wire

/* File: sto_ctl_model.sv */
// Model of the external safety controller that drives the stop pin and band comparator.
// Assumes the bench calls its tasks from a process synchronised to clock_in.
`timescale 1ns/1ps
`default_nettype none

module sto_ctl_model (
    input  wire logic clock_in,
    output var  logic stop_n_out,  // Stop pin, low means stop.
    output var  logic band_out     // High while the pin level is undefined.
);
    // The controller powers up with the stop asserted, which is the safe state.
    initial begin
        stop_n_out = 1'b0;
        band_out   = 1'b0;
    end

    // Moves the pin to a new steady level just after an edge.
    task automatic set_level(input logic lvl);
        @(posedge clock_in);
        stop_n_out <= lvl;
    endtask

    // Low-going test pulse of exactly cyc cycles, as a pulsed safety output makes.
    task automatic test_pulse(input int cyc);
        @(posedge clock_in);
        stop_n_out <= 1'b0;
        repeat (cyc) @(posedge clock_in);
        stop_n_out <= 1'b1;
    endtask

    // Puts the pin into or out of the undefined band.
    task automatic set_band(input logic b);
        @(posedge clock_in);
        band_out <= b;
    endtask
endmodule

`default_nettype wire

/* File: sto_tb.sv */
// Self-checking bench for the torque-cut supervisor with shortened filter counts.
// Assumes the controller model file and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "sto_defines.svh"

module testbench;
    localparam int PULSE = 8;   // Shortened test pulse allowance.
    localparam int BAND  = 20;  // Shortened band limit.

    logic        clock_in;         // Set up by the main process at time zero.
    logic        rst_in;
    logic        cyc;              // Bus request lines, held until ack.
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat;
    logic [3:0]  wsel;             // Byte lanes the next request uses.
    logic [31:0] rd;               // Data taken at the ack edge.
    wire  logic  stop_n;
    wire  logic  band;
    logic [31:0] wb_dat;
    logic        wb_ack;
    logic        torque;
    logic        irq;
    int          bad_count   = 0;
    int          check_count = 0;

    // Free running 25 MHz clock.
    always #20 clock_in = ~clock_in;

    sto_ctl_model ctl (.clock_in(clock_in), .stop_n_out(stop_n), .band_out(band));

    sto_supervisor #(.PULSE_CYC(PULSE), .BAND_CYC(BAND)) uut (
        .clock_in(clock_in), .rst_in(rst_in), .torque_cut_input_n(stop_n),
        .band_undef_in(band), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
        .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(wb_dat),
        .wb_ack_out(wb_ack), .torque_en_out(torque), .irq_out(irq));

    // Prints the verdict; the only place the run ends.
    task automatic wrap_up();
        if (bad_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Compares a seen value with the expected one and counts both outcomes.
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
    endtask

    // One classic cycle; everything is held until ack is sampled high, since
    // releasing early would let the slave see a half-formed request.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock_in);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        sel  <= wsel;
        do begin
            @(posedge clock_in);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        rd = wb_dat;
        check("ack", {31'h0, wb_ack}, 32'h1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input string name, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        check(name, rd, exp);
    endtask

    // Waits a bounded time for the torque output to reach a level.
    task automatic wait_tq(input logic lvl);
        int n;
        n = 0;
        while (torque !== lvl && n < 40) begin
            @(posedge clock_in);
            n++;
        end
    endtask

    // Reset values, an unmapped address, and the filtered pin reaching the status register.
    task automatic t_reset();
        rchk(`STO_OFS_ALARM, "alarm", 32'h0);
        rchk(`STO_OFS_IRQ_MASK, "mask", 32'h0);
        rchk(`STO_OFS_IRQ_STAT, "irq_stat", 32'h0);
        rchk(8'h14, "unmapped", 32'h0);
        check("torque", {31'h0, torque}, 32'h0);
        ctl.set_level(1'b1);
        tick(8);
        rchk(`STO_OFS_STAT, "stat", 32'h1);
    endtask

    // Enable with the pin high gives torque and no alarm.
    task automatic t_run();
        wb(1'b1, `STO_OFS_CTRL, 32'h1);
        wait_tq(1'b1);
        check("torque", {31'h0, torque}, 32'h1);
        rchk(`STO_OFS_STAT, "stat", 32'h7);
        rchk(`STO_OFS_ALARM, "alarm", 32'h0);
    endtask

    // A pulse of the full allowed length must pass unnoticed.
    task automatic t_pulse();
        ctl.test_pulse(PULSE);
        tick(6);
        check("torque", {31'h0, torque}, 32'h1);
        rchk(`STO_OFS_ALARM, "alarm", 32'h0);
        rchk(`STO_OFS_IRQ_STAT, "irq_stat", 32'h0);
    endtask

    // Stop while running: cut after the filter, alarm, interrupt, read-clear.
    task automatic t_stop();
        wb(1'b1, `STO_OFS_IRQ_MASK, 32'hF);
        ctl.set_level(1'b0);
        tick(PULSE);
        check("torque", {31'h0, torque}, 32'h1);
        wait_tq(1'b0);
        check("torque", {31'h0, torque}, 32'h0);
        check("irq", {31'h0, irq}, 32'h1);
        rchk(`STO_OFS_ALARM, "alarm", 32'h1);
        rchk(`STO_OFS_IRQ_STAT, "irq_stat", 32'h9);
        rchk(`STO_OFS_IRQ_STAT, "irq_stat", 32'h0);
        check("irq", {31'h0, irq}, 32'h0);
    endtask

    // Re-enable must follow pin high, clear, enable, in that order.
    task automatic t_rearm();
        wb(1'b1, `STO_OFS_CTRL, 32'h4);
        rchk(`STO_OFS_ALARM, "alarm", 32'h1);
        wb(1'b1, `STO_OFS_CTRL, 32'h1);
        tick(3);
        check("torque", {31'h0, torque}, 32'h0);
        rchk(`STO_OFS_ALARM, "alarm", 32'h3);
        ctl.set_level(1'b1);
        tick(8);
        rchk(`STO_OFS_ALARM, "alarm", 32'h3);
        wb(1'b1, `STO_OFS_CTRL, 32'h1);
        tick(4);
        check("torque", {31'h0, torque}, 32'h0);
        wb(1'b1, `STO_OFS_CTRL, 32'h4);
        rchk(`STO_OFS_ALARM, "alarm", 32'h0);
        wb(1'b1, `STO_OFS_CTRL, 32'h1);
        wait_tq(1'b1);
        check("torque", {31'h0, torque}, 32'h1);
        rchk(`STO_OFS_ALARM, "alarm", 32'h0);
    endtask

    // Disable first, then stop: no alarm may appear, only the cut event
    // and the enable-while-low event left over from the rearm scenario.
    task automatic t_disable();
        wb(1'b1, `STO_OFS_CTRL, 32'h2);
        wait_tq(1'b0);
        check("torque", {31'h0, torque}, 32'h0);
        ctl.set_level(1'b0);
        tick(20);
        rchk(`STO_OFS_ALARM, "alarm", 32'h0);
        rchk(`STO_OFS_STAT, "stat", 32'h0);
        rchk(`STO_OFS_IRQ_STAT, "irq_stat", 32'hA);
        ctl.set_level(1'b1);
        tick(8);
    endtask

    // A write without byte lane 0 is dropped. Band stay at the limit is
    // fine; one beyond it raises a masked event.
    task automatic t_band();
        wsel = 4'hE;
        wb(1'b1, `STO_OFS_IRQ_MASK, 32'h0);
        wsel = 4'hF;
        rchk(`STO_OFS_IRQ_MASK, "mask", 32'hF);
        wb(1'b1, `STO_OFS_IRQ_MASK, 32'h0);
        ctl.set_band(1'b1);
        tick(BAND - 1);
        ctl.set_band(1'b0);
        tick(6);
        rchk(`STO_OFS_ALARM, "alarm", 32'h0);
        ctl.set_band(1'b1);
        tick(BAND + 10);
        check("irq", {31'h0, irq}, 32'h0);
        rchk(`STO_OFS_ALARM, "alarm", 32'h4);
        rchk(`STO_OFS_STAT, "stat", 32'h9);
        wb(1'b1, `STO_OFS_IRQ_MASK, 32'h4);
        tick(2);
        check("irq", {31'h0, irq}, 32'h1);
        rchk(`STO_OFS_IRQ_STAT, "irq_stat", 32'h4);
        ctl.set_band(1'b0);
        tick(6);
        check("irq", {31'h0, irq}, 32'h0);
        wb(1'b1, `STO_OFS_CTRL, 32'h4);
        rchk(`STO_OFS_ALARM, "alarm", 32'h0);
    endtask

    // Main sequence: reset for three cycles, then every scenario in turn.
    initial begin
        clock_in = 1'b0;
        rst_in   = 1'b1;
        cyc      = 1'b0;
        stb      = 1'b0;
        we       = 1'b0;
        adr      = 8'h00;
        sel      = 4'h0;
        wdat     = 32'h0;
        wsel     = 4'hF;
        tick(3);
        rst_in <= 1'b0;
        t_reset();
        t_run();
        t_pulse();
        t_stop();
        t_rearm();
        t_disable();
        t_band();
        wrap_up();
    end

    // Watchdog: the scenarios need well under a thousand cycles.
    initial begin
        tick(20000);
        bad_count++;
        wrap_up();
    end
endmodule

`default_nettype wire
